// >>> bench/itm_timer_tb.sv
// Purpose: self-checking bench for the prescaled interval timer
// Assumes: 40 MHz aclk, registers reached over AXI4-Lite
// Notes: a full overflow period is too long, so the count is preloaded near its top
`timescale 1ns/1ps
module itm_timer_tb
	import itm_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp;
	int n_fail = 0, total_checks = 0;
	// 25 ns period
	initial forever #12.5 aclk = ~aclk;
	itm_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));
	// ==========================================
	// bus and compare helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// ready is sampled mid-cycle, where it is settled, and acted on at the next edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(negedge aclk);
			if (awvalid && awready) aw_ok = 1'b1;
			if (wvalid && wready) w_ok = 1'b1;
			@(posedge aclk);
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
		end
		bready <= 1'b1;
		do @(negedge aclk); while (!bvalid);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		d = rdata;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic chk_irq(input logic e);
		repeat (2) @(negedge aclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [31:0] d;
		logic [4:0] a[5] = '{5'h00, 5'h04, 5'h0c, 5'h10, 5'h14};
		logic [7:0] e[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
		for (int i = 0; i < 5; i++) begin
			rd(a[i], ITM_RESP_OKAY, d);
			chk("reset value", {24'h0, e[i]}, d);
		end
		$display("reset values done");
	endtask
	task automatic t_load();
		logic [31:0] d;
		wr(5'h08, 32'hffff_ff5a, ITM_RESP_OKAY);
		rd(5'h04, ITM_RESP_OKAY, d);
		chk("count after load", 32'h5a, d);
		$display("interval load done");
	endtask
	// two reads exactly 8192 cycles apart see one tick, whatever the phase
	task automatic t_advance();
		logic [31:0] c, d;
		rd(5'h04, ITM_RESP_OKAY, c);
		repeat (8189) @(posedge aclk);
		rd(5'h04, ITM_RESP_OKAY, d);
		chk("count step", {24'h0, c[7:0] + 8'h01}, d);
		$display("prescaled advance done");
	endtask
	task automatic t_overflow();
		logic [31:0] d;
		int n;
		wr(5'h0c, 32'h20, ITM_RESP_OKAY);
		wr(5'h14, 32'h00, ITM_RESP_OKAY);
		wr(5'h08, 32'hfe, ITM_RESP_OKAY);
		chk_irq(1'b0);
		n = 0;
		while (!irq && n < 17000) begin
			@(negedge aclk);
			n++;
		end
		chk("irq raised", 32'h1, {31'h0, irq});
		// two ticks one prescaler period apart lie between the load and the overflow
		chk("overflow spacing", 32'h1, {31'h0, (n > 8192) && (n <= 16400)});
		rd(5'h04, ITM_RESP_OKAY, d);
		chk("count wrapped", 32'h0, d);
		wr(5'h14, 32'h80, ITM_RESP_OKAY);
		chk_irq(1'b0);
		wr(5'h14, 32'h00, ITM_RESP_OKAY);
		chk_irq(1'b1);
		wr(5'h0c, 32'h00, ITM_RESP_OKAY);
		chk_irq(1'b0);
		rd(5'h10, ITM_RESP_OKAY, d);
		chk("flag set", 32'h20, d);
		rd(5'h10, ITM_RESP_OKAY, d);
		chk("flag cleared", 32'h0, d);
		wr(5'h0c, 32'h20, ITM_RESP_OKAY);
		chk_irq(1'b0);
		$display("overflow and interrupt done");
	endtask
	task automatic t_modes();
		logic [31:0] c, d;
		wr(5'h00, 32'h80, ITM_RESP_OKAY);
		rd(5'h04, ITM_RESP_OKAY, c);
		wr(5'h08, {24'h0, ~c[7:0]}, ITM_RESP_OKAY);
		rd(5'h04, ITM_RESP_OKAY, d);
		chk("load ignored", c, d);
		wr(5'h00, 32'h01, ITM_RESP_OKAY);
		rd(5'h04, ITM_RESP_OKAY, c);
		repeat (8189) @(posedge aclk);
		rd(5'h04, ITM_RESP_OKAY, d);
		chk("count held", c, d);
		wr(5'h00, 32'h00, ITM_RESP_OKAY);
		$display("mode select done");
	endtask
	task automatic t_refuse();
		logic [31:0] d;
		wr(5'h18, 32'h1, ITM_RESP_SLVERR);
		rd(5'h18, ITM_RESP_SLVERR, d);
		wr(5'h04, 32'h1, ITM_RESP_SLVERR);
		rd(5'h08, ITM_RESP_OKAY, d);
		chk("load reads zero", 32'h0, d);
		$display("refused access done");
	endtask
	// ==========================================
	// verdict, watchdog and main sequence
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// the run needs about 33000 cycles
	initial begin
		repeat (70000) @(posedge aclk);
		n_fail++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_load();
		t_advance();
		t_overflow();
		t_modes();
		t_refuse();
		tally_and_finish();
	end
endmodule

// >>> rtl/itm_pkg.sv
// Purpose: constants for the 8-bit prescaled interval timer
// Assumes: 32-bit AXI4-Lite register access, 40 MHz aclk
// Notes: register offsets are byte addresses
package itm_pkg;
	// ==========================================
	// register map
	localparam logic [3:0] ITM_OFS_MODE = 4'h0;
	localparam logic [3:0] ITM_OFS_COUNT = 4'h4;
	localparam logic [3:0] ITM_OFS_LOAD = 4'h8;
	localparam logic [3:0] ITM_OFS_ENABLE = 4'hc;
	localparam logic [4:0] ITM_OFS_FLAG5 = 5'h10;
	localparam logic [4:0] ITM_OFS_CPU = 5'h14;
	// ==========================================
	// field positions
	localparam int ITM_BIT_AUTORELOAD = 7;
	localparam int ITM_BIT_IRQ = 5;
	localparam int ITM_BIT_CPU_MASK = 7;
	localparam int ITM_PRE_W = 13;
	localparam int ITM_CNT_W = 8;
	localparam int ITM_CLKSEL_W = 3;
	// ==========================================
	// reset values and codes
	localparam logic [7:0] ITM_MODE_RST = 8'h00;
	localparam logic [7:0] ITM_CPU_RST = 8'h80;
	localparam logic [2:0] ITM_CLKSEL_INT = 3'h0;
	localparam logic [ITM_PRE_W-1:0] ITM_PRE_MAX = 13'h1fff;
	localparam logic [7:0] ITM_CNT_MAX = 8'hff;
	localparam logic [1:0] ITM_RESP_OKAY = 2'h0;
	localparam logic [1:0] ITM_RESP_SLVERR = 2'h2;
	typedef enum logic [0:0] {ITM_IDLE = 1'b0, ITM_RESP = 1'b1} itm_bus_t;
endpackage

// >>> rtl/itm_timer.sv
// Overview of operation
// RL1 - 13-bit prescaler increments every system clock cycle
// RL2 - mode register selects prescaler; counter clock is system clock over 8192
// RL3 - 8-bit read-only up-counter advances on each selected clock pulse
// RL4 - counter overflow sets the overflow request flag to one
// RL5 - 8-bit write-only load copies into counter when interval mode selected
// RL6 - interrupt taken only if flag one, enable one, cpu mask zero
// RL7 - overflow period is 256 divided-clock periods
// RL8 - autoreload select bit: zero interval mode, one autoreload mode
// RL9 - all three clock select bits zero select the internal clock
// RL10 - timer interrupt enable lives in bit 5 of enable register
// RL11 - request flag lives in bit 5 of flag register, one while requested
// RL12 - overflow wraps counter to zero in the cycle that sets the flag
// Purpose: interval timer with AXI4-Lite register access
// Assumes: single clock, synchronous active-low reset
// Notes: flag register clears on read; a same-cycle overflow wins
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module itm_timer
	import itm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	// ==========================================
	// state
	logic [ITM_PRE_W-1:0] system_prescaler;
	logic [7:0] timer_mode_reg;
	logic [ITM_CNT_W-1:0] timer_count_value;
	logic [7:0] irq_enable_reg_b;
	logic [7:0] cpu_condition_reg;
	logic overflow_request_flag;
	logic tick;
	logic ovf;
	logic have_aw;
	logic have_w;
	logic [4:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic rd_go;
	logic flag_read;
	logic load_wr;
	logic [31:0] next_rdata;
	logic next_rresp_err;
	logic wr_map;
	logic autoreload_select_bit;
	logic [ITM_CLKSEL_W-1:0] clk_sel;
	logic next_have_aw;
	logic next_have_w;
	logic next_bvalid;
	logic next_rvalid;
	logic [ITM_PRE_W-1:0] tick_gap;
	logic tick_seen;

	assign autoreload_select_bit = timer_mode_reg[ITM_BIT_AUTORELOAD];
	assign clk_sel = timer_mode_reg[ITM_CLKSEL_W-1:0];

	// ==========================================
	// prescaler
	// RL1 free running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			system_prescaler <= '0;
		end else begin
			system_prescaler <= system_prescaler + 1'b1;
		end
	end

	// RL2 divide by 8192 tap
	// RL9 internal clock select
	// the carry-out of the prescaler is a one-cycle enable, no derived clock
	assign tick = (system_prescaler == ITM_PRE_MAX) && (clk_sel == ITM_CLKSEL_INT);
	// RL7 period of 256 ticks
	// overflow is the tick that meets the top count, so it recurs every 256 ticks
	assign ovf = tick && (timer_count_value == ITM_CNT_MAX);

	// ==========================================
	// main counter
	// RL3 count on tick
	// RL12 wrap with flag
	// RL5 load in interval mode
	// RL8 mode bit gate
	// load wins over a tick in the same cycle so software sees its value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_count_value <= '0;
		end else if (load_wr && !autoreload_select_bit) begin
			timer_count_value <= w_data[ITM_CNT_W-1:0];
		end else if (tick) begin
			timer_count_value <= timer_count_value + 1'b1;
		end
	end

	// ==========================================
	// request flag
	// RL4 set on overflow
	// RL11 read clears, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_request_flag <= 1'b0;
		end else if (ovf) begin
			overflow_request_flag <= 1'b1;
		end else if (flag_read) begin
			overflow_request_flag <= 1'b0;
		end
	end

	// RL6 accept condition
	// RL10 enable gate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= overflow_request_flag && irq_enable_reg_b[ITM_BIT_IRQ]
				&& !cpu_condition_reg[ITM_BIT_CPU_MASK];
		end
	end

	// ==========================================
	// write channel
	assign wr_go = have_aw && have_w && !s_axi_bvalid;
	assign wr_map = (aw_addr == {1'b0, ITM_OFS_MODE}) || (aw_addr == {1'b0, ITM_OFS_LOAD})
		|| (aw_addr == {1'b0, ITM_OFS_ENABLE}) || (aw_addr == ITM_OFS_CPU);
	assign load_wr = wr_go && (aw_addr == {1'b0, ITM_OFS_LOAD}) && w_strb[0];

	// address and data captured in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				have_aw <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				have_w <= 1'b0;
			end
		end
	end

	// ==========================================
	// ready flags
	// what the handshake state will be after this edge; the readies are flops
	// loaded from it, so they keep the old combinational timing cycle for cycle
	always_comb begin
		next_have_aw = have_aw;
		next_have_w = have_w;
		next_bvalid = s_axi_bvalid;
		next_rvalid = s_axi_rvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			next_have_aw = 1'b1;
		end else if (wr_go) begin
			next_have_aw = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_have_w = 1'b1;
		end else if (wr_go) begin
			next_have_w = 1'b0;
		end
		if (wr_go) begin
			next_bvalid = 1'b1;
		end else if (s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rd_go) begin
			next_rvalid = 1'b1;
		end else if (s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// readies sit high in reset so the first request is taken right after release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_awready <= !next_have_aw && !next_bvalid;
			s_axi_wready <= !next_have_w && !next_bvalid;
			s_axi_arready <= !next_rvalid;
		end
	end

	// register updates, low byte lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_mode_reg <= ITM_MODE_RST;
			irq_enable_reg_b <= '0;
			cpu_condition_reg <= ITM_CPU_RST;
		end else if (wr_go && w_strb[0]) begin
			if (aw_addr == {1'b0, ITM_OFS_MODE}) begin
				timer_mode_reg <= w_data[7:0];
			end
			if (aw_addr == {1'b0, ITM_OFS_ENABLE}) begin
				irq_enable_reg_b <= w_data[7:0];
			end
			if (aw_addr == ITM_OFS_CPU) begin
				cpu_condition_reg <= w_data[7:0];
			end
		end
	end

	// response, SLVERR on unmapped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ITM_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_map ? ITM_RESP_OKAY : ITM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// read channel
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign flag_read = rd_go && (s_axi_araddr == ITM_OFS_FLAG5);

	// load register is write-only and reads as zero
	always_comb begin
		next_rdata = '0;
		next_rresp_err = 1'b0;
		case (s_axi_araddr)
			{1'b0, ITM_OFS_MODE}: next_rdata[7:0] = timer_mode_reg;
			{1'b0, ITM_OFS_COUNT}: next_rdata[7:0] = timer_count_value;
			{1'b0, ITM_OFS_LOAD}: next_rdata = '0;
			{1'b0, ITM_OFS_ENABLE}: next_rdata[7:0] = irq_enable_reg_b;
			ITM_OFS_FLAG5: next_rdata[ITM_BIT_IRQ] = overflow_request_flag;
			ITM_OFS_CPU: next_rdata[7:0] = cpu_condition_reg;
			default: next_rresp_err = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ITM_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp_err ? ITM_RESP_SLVERR : ITM_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================
	// checks
	// cycles since the last tick; a repetition spans one whole prescaler period,
	// so a counter as wide as the prescaler carries it, and a stopped clock select forgets the last tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_gap <= '0;
			tick_seen <= 1'b0;
		end else if (tick) begin
			tick_gap <= '0;
			tick_seen <= 1'b1;
		end else if (clk_sel != ITM_CLKSEL_INT) begin
			tick_gap <= '0;
			tick_seen <= 1'b0;
		end else begin
			tick_gap <= tick_gap + 1'b1;
		end
	end

	// RL7 no early tick
	AST_TICK_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
		tick |=> !tick [*8])
		else $error("tick repeated too soon");
	// RL7 full prescaler period
	AST_TICK_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
		tick && tick_seen |-> tick_gap == ITM_PRE_MAX)
		else $error("tick spacing is not one prescaler period");
	// RL4 overflow sets flag
	AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
		ovf |=> overflow_request_flag)
		else $error("overflow did not set flag");
	// RL12 wrap to zero
	AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
		ovf && !load_wr |=> timer_count_value == 8'h00)
		else $error("counter did not wrap");
	// RL3 count only on tick
	AST_COUNT_STEP: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
		!tick && !load_wr |=> $stable(timer_count_value))
		else $error("counter moved without tick");
	// RL5 interval load copies
	AST_LOAD: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
		load_wr && !autoreload_select_bit |=> timer_count_value == $past(w_data[7:0]))
		else $error("load not copied");
	// RL8 autoreload ignores load
	AST_NO_LOAD_AR: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		load_wr && autoreload_select_bit && !tick |=> $stable(timer_count_value))
		else $error("load taken in autoreload mode");
	// RL6 all three conditions
	AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
		irq |-> $past(overflow_request_flag) && $past(irq_enable_reg_b[ITM_BIT_IRQ])
			&& !$past(cpu_condition_reg[ITM_BIT_CPU_MASK]))
		else $error("irq without cause");
	// RL11 read clears flag
	AST_READ_CLR: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
		flag_read && !ovf |=> !overflow_request_flag)
		else $error("flag not cleared by read");
	// RL1 prescaler steps by one
	AST_PRESCALE: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		1'b1 |=> system_prescaler == $past(system_prescaler) + 13'h0001)
		else $error("prescaler skipped");
	// RL9 internal clock only
	AST_CLKSEL: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
		clk_sel != ITM_CLKSEL_INT |-> !tick)
		else $error("tick with external select");
	// RL10 enable gates irq
	AST_IRQ_EN: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
		!irq_enable_reg_b[ITM_BIT_IRQ] |=> !irq)
		else $error("irq while disabled");
	// RL2 tick on tap
	AST_DIV: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
		tick |-> system_prescaler == ITM_PRE_MAX)
		else $error("tick off tap");
	// main scenarios reached
	COV_OVF: cover property (@(posedge aclk) ovf);
	COV_IRQ: cover property (@(posedge aclk) irq);
	COV_LOAD: cover property (@(posedge aclk) load_wr && !autoreload_select_bit);
	COV_SETCLR: cover property (@(posedge aclk) ovf && flag_read);
	COV_MASKED: cover property (@(posedge aclk) overflow_request_flag
		&& irq_enable_reg_b[ITM_BIT_IRQ] && cpu_condition_reg[ITM_BIT_CPU_MASK]);
endmodule
